//--- include/obcd_pkg.sv
package obcd_pkg;

    ////////////////////////////////////////////////////////////////////////
    // reset values and erased content
    localparam logic [7:0] OPT0_RST = 8'hfc;
    localparam logic [7:0] OPT1_RST = 8'hef;
    localparam logic [7:0] ERASED   = 8'hff;

    ////////////////////////////////////////////////////////////////////////
    // field positions, byte 0
    localparam int B0_AWU      = 7;
    localparam int B0_RANGE_LO = 4;
    localparam int B0_SEC_LO   = 2;
    localparam int B0_RDP      = 1;
    localparam int B0_WRP      = 0;
    // field positions, byte 1
    localparam int B1_PLLX8    = 7;
    localparam int B1_PLL_BYPASS   = 6;
    localparam int B1_RSV      = 5;
    localparam int B1_RCOFF    = 4;
    localparam int B1_VD_LO    = 2;
    localparam int B1_WATCHDOG_MODE_SELECT    = 1;
    localparam int B1_HALT     = 0;

    ////////////////////////////////////////////////////////////////////////
    // encodings
    localparam logic [2:0]  RANGE_1_TO_2  = 3'h0;
    localparam logic [2:0]  RANGE_2_TO_4  = 3'h1;
    localparam logic [2:0]  RANGE_4_TO_8  = 3'h2;
    localparam logic [2:0]  RANGE_8_TO_16 = 3'h3;
    localparam logic [2:0]  RANGE_VLP     = 3'h4;
    localparam logic [2:0]  RANGE_EXT_PB4 = 3'h7;
    localparam logic [12:0] SEC_0K5       = 13'h0200;
    localparam logic [12:0] SEC_1K        = 13'h0400;
    localparam logic [12:0] SEC_2K        = 13'h0800;
    localparam logic [12:0] SEC_4K        = 13'h1000;
    localparam logic [1:0]  VD_OFF        = 2'h3;
    localparam logic [3:0]  PLL_X4        = 4'h4;
    localparam logic [3:0]  PLL_X8        = 4'h8;
    localparam logic [7:0]  WRP_MASK      = 8'h01;

    typedef enum logic [2:0] {
        CMD_OPT_RD,
        CMD_OPT_WR,
        CMD_OPT_ERASE,
        CMD_PM_RD,
        CMD_PM_WR,
        CMD_PM_ERASE
    } obcd_cmd_t;

    typedef struct packed {
        logic        valid;
        obcd_cmd_t   cmd;
        logic        idx;
        logic [7:0]  wdata;
    } obcd_req_t;

    typedef struct packed {
        logic        done;
        logic        refused;
        logic [7:0]  rdata;
    } obcd_rsp_t;

    typedef struct packed {
        logic        wr_en;
        logic        idx;
        logic [7:0]  data;
        logic        erase_all;
    } obcd_nvm_t;

    typedef struct packed {
        logic        awu_rc;
        logic [2:0]  osc_range;
        logic        ext_clk_pb4;
        logic [12:0] sector0_bytes;
        logic        rd_protect;
        logic        wr_protect;
        logic [3:0]  pll_mult;
        logic        pll_enable;
        logic        rc_osc_on;
        logic        vd_enable;
        logic [1:0]  vd_level;
        logic        wdg_hw_on;
        logic        halt_reset;
    } obcd_cfg_t;

    function automatic obcd_cfg_t obcd_decode(input logic [7:0] b0,
                                              input logic [7:0] b1);
        obcd_cfg_t c;
        c = '0;
        c.awu_rc      = b0[B0_AWU];
        c.osc_range   = c.awu_rc ? b0[B0_RANGE_LO +: 3]
                                 : RANGE_VLP;
        c.rc_osc_on   = !b1[B1_RCOFF];
        c.ext_clk_pb4 = !c.rc_osc_on
                        && (c.osc_range == RANGE_EXT_PB4);
        unique case (b0[B0_SEC_LO +: 2])
            2'h0: c.sector0_bytes = SEC_0K5;
            2'h1: c.sector0_bytes = SEC_1K;
            2'h2: c.sector0_bytes = SEC_2K;
            2'h3: c.sector0_bytes = SEC_4K;
        endcase
        c.rd_protect  = b0[B0_RDP];
        c.wr_protect  = b0[B0_WRP];
        c.pll_mult    = b1[B1_PLLX8] ? PLL_X8 : PLL_X4;
        c.pll_enable  = !b1[B1_PLL_BYPASS];
        c.vd_level    = b1[B1_VD_LO +: 2];
        c.vd_enable   = (c.vd_level != VD_OFF);
        c.wdg_hw_on   = !b1[B1_WATCHDOG_MODE_SELECT];
        c.halt_reset  = b1[B1_HALT];
        return c;
    endfunction

endpackage

//--- rtl/obcd_option_decoder.sv
// Behaviour
// - wake-up clock: 0 low-power osc, 1 RC
// - range field picks resonator or external clock
// - range ignored when wake-up bit is 0
// - sector 0 size 0.5k, 1k, 2k, 4k
// - read-out protection blocks extraction and writes
// - erase under read protection without write protection erases everything first
// - write protection refuses program memory writes and all erase; without read protection, option byte writes go through with the bit held
// - option bytes reachable only in programming mode
// - erased flash reads back as all ones
// - pll factor: 0 times four, 1 times eight
// - pll bypass bit: 0 enabled, 1 bypassed
// - rc oscillator on when 0, off when 1
// - voltage detect threshold field, 11 is off
// - watchdog mode: 0 hardware, 1 software
// - halt-reset bit: reset on halt entry when 1
`timescale 1ns/1ns
`default_nettype none

module obcd_option_decoder
    import obcd_pkg::*;
(
    // clock and reset
    input  wire logic      clk_sys,
    input  wire logic      rst,
    // non-volatile option cells
    input  wire logic [7:0] nvm_byte0,
    input  wire logic [7:0] nvm_byte1,
    // programming tool port
    input  wire logic      prog_mode,
    input  wire obcd_req_t prog_req,
    output var  obcd_rsp_t prog_rsp,
    output var  logic      pm_grant,
    // option cell programming strobes
    output var  obcd_nvm_t nvm_cmd,
    // decoded hardware settings
    output var  obcd_cfg_t cfg,
    output var  logic      cfg_valid
);

    ////////////////////////////////////////////////////////////////////////
    // state

    typedef enum logic {
        PH_LOAD,
        PH_RUN
    } obcd_phase_t;

    typedef struct packed {
        obcd_phase_t phase;
        logic [7:0]  opt0;
        logic [7:0]  opt1;
        logic        unlocked;
        obcd_cfg_t   cfg;
        obcd_rsp_t   rsp;
        obcd_nvm_t   nvm;
        logic        pm_grant;
    } obcd_state_t;

    obcd_state_t st_reg;
    obcd_state_t st_next;
    logic        rd_prot;
    logic        wr_prot;

    // a mass erase lifts read protection until the next reset, since the
    // latched bytes are only refreshed on reset
    assign rd_prot = st_reg.cfg.rd_protect && !st_reg.unlocked;
    assign wr_prot = st_reg.cfg.wr_protect;

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        st_next               = st_reg;
        st_next.rsp.done      = 1'b0;
        st_next.rsp.refused   = 1'b0;
        st_next.nvm.wr_en     = 1'b0;
        st_next.nvm.erase_all = 1'b0;
        st_next.pm_grant      = 1'b0;
        unique case (st_reg.phase)
            PH_LOAD: begin
                // settings come from the cells exactly once per reset
                st_next.opt0  = nvm_byte0;
                st_next.opt1  = nvm_byte1;
                st_next.cfg   = obcd_decode(nvm_byte0, nvm_byte1);
                st_next.phase = PH_RUN;
            end
            PH_RUN: begin
                if (prog_req.valid) begin
                    st_next.rsp.done = 1'b1;
                    if (!prog_mode) begin
                        st_next.rsp.refused = 1'b1;
                    end else begin
                        unique case (prog_req.cmd)
                            CMD_OPT_RD: begin
                                st_next.rsp.rdata = prog_req.idx
                                                    ? nvm_byte1
                                                    : nvm_byte0;
                            end
                            CMD_OPT_WR: begin
                                if (rd_prot) begin
                                    st_next.rsp.refused = 1'b1;
                                end else begin
                                    st_next.nvm.wr_en = 1'b1;
                                    st_next.nvm.idx   = prog_req.idx;
                                    st_next.nvm.data  = prog_req.wdata;
                                    // protection bit cannot be cleared
                                    if (wr_prot && !prog_req.idx) begin
                                        st_next.nvm.data =
                                            prog_req.wdata | WRP_MASK;
                                    end
                                end
                            end
                            CMD_OPT_ERASE: begin
                                if (wr_prot) begin
                                    st_next.rsp.refused = 1'b1;
                                end else if (rd_prot) begin
                                    st_next.nvm.erase_all = 1'b1;
                                    st_next.unlocked      = 1'b1;
                                end else begin
                                    st_next.nvm.wr_en = 1'b1;
                                    st_next.nvm.idx   = prog_req.idx;
                                    st_next.nvm.data  = ERASED;
                                end
                            end
                            CMD_PM_RD: begin
                                if (rd_prot) begin
                                    st_next.rsp.refused = 1'b1;
                                end else begin
                                    st_next.pm_grant = 1'b1;
                                end
                            end
                            CMD_PM_WR, CMD_PM_ERASE: begin
                                if (rd_prot || wr_prot) begin
                                    st_next.rsp.refused = 1'b1;
                                end else begin
                                    st_next.pm_grant = 1'b1;
                                end
                            end
                            default: begin
                                st_next.rsp.refused = 1'b1;
                            end
                        endcase
                    end
                end
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_reg       <= '0;
            st_reg.phase <= PH_LOAD;
            st_reg.opt0  <= OPT0_RST;
            st_reg.opt1  <= OPT1_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    assign prog_rsp  = st_reg.rsp;
    assign pm_grant  = st_reg.pm_grant;
    assign nvm_cmd   = st_reg.nvm;
    assign cfg       = st_reg.cfg;
    assign cfg_valid = (st_reg.phase == PH_RUN);

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    logic run_q;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            run_q <= 1'b0;
        end else begin
            run_q <= (st_reg.phase == PH_RUN);
        end
    end

    chk_mode_gate_refuse: assert property (
        (st_reg.phase == PH_RUN) && prog_req.valid && !prog_mode
        |=> prog_rsp.done && prog_rsp.refused && !nvm_cmd.wr_en
            && !pm_grant)
        else $error("access outside programming mode not refused");

    chk_rdp_read_block: assert property (
        (st_reg.phase == PH_RUN) && prog_req.valid && prog_mode
        && prog_req.cmd == CMD_PM_RD && rd_prot
        |=> prog_rsp.refused && !pm_grant)
        else $error("program memory read granted under read protection");

    chk_wrp_pm_block: assert property (
        (st_reg.phase == PH_RUN) && prog_req.valid && prog_mode
        && (prog_req.cmd == CMD_PM_WR || prog_req.cmd == CMD_PM_ERASE)
        && wr_prot
        |=> prog_rsp.refused && !pm_grant)
        else $error("program or erase allowed under write protection");

    chk_wrp_bit_kept: assert property (
        nvm_cmd.wr_en && !nvm_cmd.idx && cfg.wr_protect
        |-> nvm_cmd.data[B0_WRP])
        else $error("write protection bit cleared");

    chk_rdp_mass_erase: assert property (
        (st_reg.phase == PH_RUN) && prog_req.valid && prog_mode
        && prog_req.cmd == CMD_OPT_ERASE && rd_prot && !wr_prot
        |=> nvm_cmd.erase_all && !nvm_cmd.wr_en ##1 !nvm_cmd.erase_all)
        else $error("protected option erase without mass erase");

    chk_erase_all_ones: assert property (
        (st_reg.phase == PH_RUN) && prog_req.valid && prog_mode
        && prog_req.cmd == CMD_OPT_ERASE && !rd_prot && !wr_prot
        |=> nvm_cmd.wr_en && nvm_cmd.data == ERASED)
        else $error("erase did not write all ones");

    chk_cfg_held: assert property (
        run_q |-> $stable(cfg) && cfg_valid)
        else $error("decoded settings changed before reset");

    chk_range_vlp: assert property (
        cfg_valid && !cfg.awu_rc |-> cfg.osc_range == RANGE_VLP)
        else $error("range not forced with low-power wake-up clock");

    chk_pll_factor: assert property (
        cfg_valid |-> cfg.pll_mult
            == (st_reg.opt1[B1_PLLX8] ? PLL_X8 : PLL_X4))
        else $error("pll factor does not match option byte");

    chk_vd_enable: assert property (
        cfg_valid |-> cfg.vd_enable
            == (st_reg.opt1[B1_VD_LO +: 2] != VD_OFF))
        else $error("voltage detector enable wrong");

    // the settings checks below lean on opt0/opt1, so prove the capture
    chk_bytes_latched: assert property (
        !cfg_valid |=> cfg_valid && st_reg.opt0 == $past(nvm_byte0)
            && st_reg.opt1 == $past(nvm_byte1))
        else $error("option bytes not captured on the load cycle");

    chk_awu_source: assert property (
        cfg_valid |-> cfg.awu_rc == st_reg.opt0[B0_AWU])
        else $error("wake-up clock source wrong");

    chk_ext_clock: assert property (
        cfg_valid |-> cfg.ext_clk_pb4
            == (st_reg.opt0[B0_AWU] && st_reg.opt1[B1_RCOFF]
                && st_reg.opt0[B0_RANGE_LO +: 3] == RANGE_EXT_PB4))
        else $error("external clock selection wrong");

    chk_range_raw: assert property (
        cfg_valid && cfg.awu_rc
        |-> cfg.osc_range == st_reg.opt0[B0_RANGE_LO +: 3])
        else $error("oscillator range not taken from option byte");

    chk_sector_size: assert property (
        cfg_valid |-> cfg.sector0_bytes
            == (SEC_0K5 << st_reg.opt0[B0_SEC_LO +: 2]))
        else $error("sector 0 size wrong");

    chk_protect_bits: assert property (
        cfg_valid |-> cfg.rd_protect == st_reg.opt0[B0_RDP]
            && cfg.wr_protect == st_reg.opt0[B0_WRP])
        else $error("protection settings wrong");

    chk_pll_bypass: assert property (
        cfg_valid |-> cfg.pll_enable == !st_reg.opt1[B1_PLL_BYPASS])
        else $error("pll bypass setting wrong");

    chk_rc_source: assert property (
        cfg_valid |-> cfg.rc_osc_on == !st_reg.opt1[B1_RCOFF])
        else $error("rc oscillator setting wrong");

    chk_vd_level: assert property (
        cfg_valid |-> cfg.vd_level == st_reg.opt1[B1_VD_LO +: 2])
        else $error("voltage detector threshold wrong");

    chk_wdg_mode: assert property (
        cfg_valid |-> cfg.wdg_hw_on == !st_reg.opt1[B1_WATCHDOG_MODE_SELECT])
        else $error("watchdog mode wrong");

    chk_halt_reset: assert property (
        cfg_valid |-> cfg.halt_reset == st_reg.opt1[B1_HALT])
        else $error("halt reset setting wrong");

    chk_refused_quiet: assert property (
        prog_rsp.refused |-> prog_rsp.done && !nvm_cmd.wr_en
            && !nvm_cmd.erase_all && !pm_grant)
        else $error("refused request still produced a strobe");

    chk_rdp_opt_write: assert property (
        (st_reg.phase == PH_RUN) && prog_req.valid && prog_mode
        && prog_req.cmd == CMD_OPT_WR && rd_prot
        |=> prog_rsp.refused && !nvm_cmd.wr_en)
        else $error("option write accepted under read protection");

    chk_wrp_opt_erase: assert property (
        (st_reg.phase == PH_RUN) && prog_req.valid && prog_mode
        && prog_req.cmd == CMD_OPT_ERASE && wr_prot
        |=> prog_rsp.refused && !nvm_cmd.wr_en && !nvm_cmd.erase_all)
        else $error("option erase accepted under write protection");

    chk_answer_next: assert property (
        (st_reg.phase == PH_RUN) && prog_req.valid |=> prog_rsp.done)
        else $error("request not answered in the next cycle");

    cov_opt_write: cover property (nvm_cmd.wr_en && !nvm_cmd.idx);
    cov_mass_erase: cover property (nvm_cmd.erase_all);
    cov_pm_grant: cover property (pm_grant);
    cov_refused: cover property (prog_rsp.refused && prog_rsp.done);
    cov_ext_clock: cover property (cfg_valid && cfg.ext_clk_pb4);

endmodule

`default_nettype wire

//--- verification/obcd_nvm_model.sv
`timescale 1ns/1ns
`default_nettype none

module obcd_nvm_model
    import obcd_pkg::*;
(
    // clock
    input  wire logic       clk_sys,
    // preload from the bench
    input  wire logic       load,
    input  wire logic [7:0] load_b0,
    input  wire logic [7:0] load_b1,
    // strobes in, cell content out
    input  wire obcd_nvm_t  nvm_cmd,
    output var  logic [7:0] nvm_byte0,
    output var  logic [7:0] nvm_byte1
);

    ////////////////////////////////////////////////////////////////////////
    // cells are non-volatile: device reset leaves them alone
    initial begin
        nvm_byte0 = ERASED;
        nvm_byte1 = ERASED;
    end

    always @(posedge clk_sys) begin
        if (load) begin
            nvm_byte0 <= load_b0;
            nvm_byte1 <= load_b1;
        end else if (nvm_cmd.erase_all) begin
            nvm_byte0 <= ERASED;
            nvm_byte1 <= ERASED;
        end else if (nvm_cmd.wr_en && nvm_cmd.idx) begin
            nvm_byte1 <= nvm_cmd.data;
        end else if (nvm_cmd.wr_en) begin
            nvm_byte0 <= nvm_cmd.data;
        end
    end

endmodule

`default_nettype wire

//--- verification/testbench.sv
`timescale 1ns/1ns
`default_nettype none

module testbench
    import obcd_pkg::*;
;
    logic       clk_sys = 1'b0;
    logic       rst = 1'b1;
    logic       prog_mode = 1'b0;
    obcd_req_t  prog_req = '0;
    obcd_rsp_t  prog_rsp;
    logic       pm_grant;
    obcd_nvm_t  nvm_cmd;
    obcd_nvm_t  nvm_seen;
    obcd_cfg_t  cfg;
    logic       cfg_valid;
    logic [7:0] nvm_byte0;
    logic [7:0] nvm_byte1;
    logic       load = 1'b1;
    logic [7:0] load_b0 = 8'hff;
    logic [7:0] load_b1 = 8'hff;
    int         mismatches = 0;
    int         checks_done = 0;
    int         cycles = 0;

    always #50 clk_sys = ~clk_sys;

    obcd_option_decoder uut (.clk_sys(clk_sys), .rst(rst),
        .nvm_byte0(nvm_byte0), .nvm_byte1(nvm_byte1),
        .prog_mode(prog_mode), .prog_req(prog_req), .prog_rsp(prog_rsp),
        .pm_grant(pm_grant), .nvm_cmd(nvm_cmd), .cfg(cfg),
        .cfg_valid(cfg_valid));

    obcd_nvm_model cells (.clk_sys(clk_sys), .load(load),
        .load_b0(load_b0), .load_b1(load_b1), .nvm_cmd(nvm_cmd),
        .nvm_byte0(nvm_byte0), .nvm_byte1(nvm_byte1));

    ////////////////////////////////////////////////////////////////////////
    task automatic final_report;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // whole run is under a hundred cycles; this only catches a hang
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 2000) begin
            mismatches++;
            final_report();
        end
    end

    task automatic compare(input string what, input logic [15:0] exp,
                           input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // preload cells, then reset so the decoder picks them up
    task automatic boot(input logic [7:0] b0, input logic [7:0] b1);
        load_b0 = b0;
        load_b1 = b1;
        load = 1'b1;
        rst = 1'b1;
        @(posedge clk_sys);
        #10 load = 1'b0;
        repeat (4) @(posedge clk_sys);
        #10 rst = 1'b0;
        @(posedge clk_sys);
        #10;
    endtask

    // one request; response and strobes are caught in the one cycle in
    // which they stand, then valid stays low across an edge before the
    // next call, so back-to-back calls never re-raise it in one step
    task automatic req(input obcd_cmd_t cmd, input logic idx,
                       input logic [7:0] wd, input logic rf, input logic gr);
        prog_req.valid = 1'b1;
        prog_req.cmd = cmd;
        prog_req.idx = idx;
        prog_req.wdata = wd;
        @(posedge clk_sys);
        #10;
        prog_req.valid = 1'b0;
        nvm_seen = nvm_cmd;
        compare("rsp", {13'h0, 1'b1, rf, gr},
                {13'h0, prog_rsp.done, prog_rsp.refused, pm_grant});
        @(posedge clk_sys);
        #10;
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_defaults;
        boot(8'hfc, 8'hef);
        compare("cfg_valid", 16'h1, cfg_valid);
        compare("awu_rc", 16'h1, cfg.awu_rc);
        compare("rc_osc_on", 16'h1, cfg.rc_osc_on);
        compare("ext_clk", 16'h0, cfg.ext_clk_pb4);
        compare("sector0", 16'h1000, cfg.sector0_bytes);
        compare("protect", 16'h0, {cfg.rd_protect, cfg.wr_protect});
        compare("pll_mult", 16'h8, cfg.pll_mult);
        compare("pll_enable", 16'h0, cfg.pll_enable);
        compare("vd_enable", 16'h0, cfg.vd_enable);
        compare("wdg_hw_on", 16'h0, cfg.wdg_hw_on);
        compare("halt_reset", 16'h1, cfg.halt_reset);
    endtask

    task automatic t_decode;
        logic [1:0] k;
        logic [2:0] rng;
        for (int i = 0; i < 4; i++) begin
            k = i[1:0];
            rng = (i == 3) ? 3'h7 : {1'b0, k};
            boot({1'b1, rng, k, 2'b00}, {4'b0011, k, 2'b00});
            compare("sector0", 16'h0200 << i, cfg.sector0_bytes);
            compare("vd_level", k, cfg.vd_level);
            compare("vd_enable", i != 3, cfg.vd_enable);
            compare("osc_range", rng, cfg.osc_range);
            compare("ext_clk", i == 3, cfg.ext_clk_pb4);
            compare("rc_osc_on", 16'h0, cfg.rc_osc_on);
            compare("pll_enable", 16'h1, cfg.pll_enable);
            compare("pll_mult", 16'h4, cfg.pll_mult);
            compare("wdg_hw_on", 16'h1, cfg.wdg_hw_on);
            compare("halt_reset", 16'h0, cfg.halt_reset);
        end
        boot(8'h7c, 8'hef);
        compare("awu_rc", 16'h0, cfg.awu_rc);
        compare("osc_range", 16'h4, cfg.osc_range);
    endtask

    task automatic t_prog;
        boot(8'hfc, 8'hef);
        req(CMD_OPT_RD, 1'b0, 8'h00, 1'b1, 1'b0);
        prog_mode = 1'b1;
        req(CMD_OPT_WR, 1'b1, 8'h2f, 1'b0, 1'b0);
        compare("wr_en", 16'h1, nvm_seen.wr_en);
        compare("wr_idx", 16'h1, nvm_seen.idx);
        compare("wr_data", 16'h2f, nvm_seen.data);
        req(CMD_OPT_RD, 1'b1, 8'h00, 1'b0, 1'b0);
        compare("rdata", 16'h2f, prog_rsp.rdata);
        compare("pll_mult", 16'h8, cfg.pll_mult);
        req(CMD_OPT_ERASE, 1'b0, 8'h00, 1'b0, 1'b0);
        compare("erase_en", 16'h1, nvm_seen.wr_en);
        compare("erase_all", 16'h0, nvm_seen.erase_all);
        compare("erase_idx", 16'h0, nvm_seen.idx);
        compare("erase_data", 16'hff, nvm_seen.data);
        req(CMD_OPT_RD, 1'b0, 8'h00, 1'b0, 1'b0);
        compare("erased", 16'hff, prog_rsp.rdata);
        req(obcd_cmd_t'(3'h7), 1'b0, 8'h00, 1'b1, 1'b0);
        req(CMD_PM_WR, 1'b0, 8'h00, 1'b0, 1'b1);
    endtask

    task automatic t_readprot;
        boot(8'hfe, 8'hef);
        compare("protect", 16'h2, {cfg.rd_protect, cfg.wr_protect});
        req(CMD_PM_RD, 1'b0, 8'h00, 1'b1, 1'b0);
        req(CMD_PM_WR, 1'b0, 8'h00, 1'b1, 1'b0);
        req(CMD_OPT_WR, 1'b0, 8'hfc, 1'b1, 1'b0);
        compare("no_write", 16'h0, nvm_seen.wr_en);
        req(CMD_OPT_ERASE, 1'b0, 8'h00, 1'b0, 1'b0);
        compare("erase_all", 16'h1, nvm_seen.erase_all);
        compare("erase_wr", 16'h0, nvm_seen.wr_en);
        req(CMD_OPT_RD, 1'b1, 8'h00, 1'b0, 1'b0);
        compare("wiped", 16'hff, prog_rsp.rdata);
        req(CMD_PM_WR, 1'b0, 8'h00, 1'b0, 1'b1);
    endtask

    task automatic t_writeprot;
        boot(8'hfd, 8'hef);
        compare("protect", 16'h1, {cfg.rd_protect, cfg.wr_protect});
        req(CMD_PM_ERASE, 1'b0, 8'h00, 1'b1, 1'b0);
        req(CMD_PM_WR, 1'b0, 8'h00, 1'b1, 1'b0);
        req(CMD_OPT_ERASE, 1'b0, 8'h00, 1'b1, 1'b0);
        req(CMD_OPT_WR, 1'b0, 8'h00, 1'b0, 1'b0);
        compare("wp_bit", 16'h01, nvm_seen.data);
        req(CMD_PM_RD, 1'b0, 8'h00, 1'b0, 1'b1);
    endtask

    initial begin
        t_defaults();
        t_decode();
        t_prog();
        t_readprot();
        t_writeprot();
        final_report();
    end

endmodule

`default_nettype wire
